// ### core/cfsp_map.svh
`ifndef CFSP_MAP_SVH
`define CFSP_MAP_SVH

// ----------------------------------------------------------------------------
// Condition flag field positions
// ----------------------------------------------------------------------------
`define CFSP_BIT_CARRY     0
`define CFSP_BIT_ZERO      1
`define CFSP_BIT_NEGATIVE  2
`define CFSP_BIT_PRIO_LOW  3
`define CFSP_BIT_HALF      4
`define CFSP_BIT_PRIO_HIGH 5
`define CFSP_FLAGS_RESET   8'hE8
`define CFSP_FLAGS_ONES    8'hC0

// ----------------------------------------------------------------------------
// Priority field encodings, high bit first
// ----------------------------------------------------------------------------
`define CFSP_PRIO_LEVEL0   2'h2
`define CFSP_PRIO_LEVEL1   2'h1
`define CFSP_PRIO_LEVEL2   2'h0
`define CFSP_PRIO_LEVEL3   2'h3

// ----------------------------------------------------------------------------
// Stack pointer
// ----------------------------------------------------------------------------
`define CFSP_STACK_PAGE    8'h01
`define CFSP_STACK_RESET   16'h01FF
`define CFSP_STACK_LOW_RST 8'hFF
`define CFSP_CALL_BYTES    3'h2
`define CFSP_IRQ_BYTES     3'h5

`endif

// ### core/cfsp_pkg.sv
package cfsp_pkg;

   typedef enum logic [3:0] {
      CFSP_OP_NONE     = 4'h0,
      CFSP_OP_ADD      = 4'h1,
      CFSP_OP_LOGIC    = 4'h2,
      CFSP_OP_ARITH    = 4'h3,
      CFSP_OP_SHIFT    = 4'h4,
      CFSP_OP_BITTEST  = 4'h5,
      CFSP_OP_SETC     = 4'h6,
      CFSP_OP_CLRC     = 4'h7,
      CFSP_OP_PRIOWR   = 4'h8,
      CFSP_OP_FLAGSWR  = 4'h9
   } cfsp_op_e;

   typedef enum logic [3:0] {
      CFSP_SP_NONE     = 4'h0,
      CFSP_SP_PUSH     = 4'h1,
      CFSP_SP_POP      = 4'h2,
      CFSP_SP_LOAD     = 4'h3,
      CFSP_SP_RESET    = 4'h4,
      CFSP_SP_CALL     = 4'h5,
      CFSP_SP_RET      = 4'h6,
      CFSP_SP_IRQ      = 4'h7,
      CFSP_SP_IRQ_RETURN_INSTR     = 4'h8
   } cfsp_spop_e;

   typedef enum logic [2:0] {
      CFSP_ST_IDLE     = 3'h0,
      CFSP_ST_PUSHSEQ  = 3'h1,
      CFSP_ST_POPSEQ   = 3'h2
   } cfsp_state_e;

   typedef struct packed {
      cfsp_op_e    op;
      logic [7:0]  result;
      logic        carry;
      logic        halfCarry;
      logic [7:0]  value;
   } cfsp_alu_s;

   typedef struct packed {
      cfsp_spop_e  op;
      logic [7:0]  lowByte;
      logic [7:0]  pcLow;
      logic [7:0]  pcHigh;
      logic [7:0]  indexReg;
      logic [7:0]  accum;
      logic [1:0]  entryPrio;
   } cfsp_stack_req_s;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [15:0] addr;
      logic [7:0]  data;
   } cfsp_mem_s;

endpackage

// ### core/cfsp_stack_ptr.sv
`timescale 1ns/1ps
`include "cfsp_map.svh"

module cfsp_stack_ptr (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       reload,
   input  wire logic       load,
   input  wire logic [7:0] loadValue,
   input  wire logic       decrement,
   input  wire logic       increment,
   output logic [7:0]      lowByte
);
   import cfsp_pkg::*;

   logic [7:0] next_lowByte;

   // Eight-bit arithmetic gives the wrap in both directions with no overflow flag.
   always_comb begin
      next_lowByte = lowByte;
      if (reload) begin
         next_lowByte = `CFSP_STACK_LOW_RST;
      end else if (load) begin
         next_lowByte = loadValue;
      end else if (decrement) begin
         next_lowByte = lowByte - 8'h01;
      end else if (increment) begin
         next_lowByte = lowByte + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lowByte <= `CFSP_STACK_LOW_RST;
      end else begin
         lowByte <= next_lowByte;
      end
   end

   property p_wrap_down;
      @(posedge ref_clk) disable iff (!reset_n)
      (decrement && !reload && !load && lowByte == 8'h00) |=> lowByte == 8'hFF;
   endproperty
   a_wrap_down: assert property (p_wrap_down) else $error("stack did not wrap downward");

   property p_wrap_up;
      @(posedge ref_clk) disable iff (!reset_n)
      (increment && !decrement && !reload && !load && lowByte == 8'hFF) |=> lowByte == 8'h00;
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("stack did not wrap upward");

endmodule

// ### core/cfsp_core_regs.sv
`timescale 1ns/1ps
`include "cfsp_map.svh"

// How it works
// - add sets half carry from bit three
// - negative copies result bit seven
// - zero set when result is zero
// - carry shows arithmetic overflow or underflow
// - carry forced by set/clear, shifts, bit tests
// - bits five and three encode priority level
// - interrupt entry loads priority from source
// - priority writable by listed instructions
// - flags pushed, popped and individually testable
// - sixteen-bit pointer, fixed upper byte
// - reset or reload gives top address
// - push writes then decrements; pop increments first
// - pointer wraps silently at both limits
// - low byte loadable and readable directly
// - call two bytes, interrupt five bytes
module cfsp_core_regs (
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire cfsp_pkg::cfsp_alu_s       aluReq,
   input  wire cfsp_pkg::cfsp_stack_req_s stackReq,
   input  wire logic [7:0]                memReadData,
   output cfsp_pkg::cfsp_mem_s            memPort,
   output logic [7:0]                     condition_flags,
   output logic [15:0]                    stack_top_pointer,
   output logic [3:0]                     branchTests,
   output logic [1:0]                     priorityLevel,
   output logic [7:0]                     popData,
   output logic                           popValid,
   output logic                           busy
);
   import cfsp_pkg::*;

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   function automatic logic [1:0] prio_level(input logic [1:0] field);
      case (field)
         `CFSP_PRIO_LEVEL0: prio_level = 2'h0;
         `CFSP_PRIO_LEVEL1: prio_level = 2'h1;
         `CFSP_PRIO_LEVEL2: prio_level = 2'h2;
         default:           prio_level = 2'h3;
      endcase
   endfunction

   function automatic logic [7:0] set_prio(input logic [7:0] flags, input logic [1:0] field);
      logic [7:0] r;
      r = flags;
      r[`CFSP_BIT_PRIO_HIGH] = field[1];
      r[`CFSP_BIT_PRIO_LOW]  = field[0];
      set_prio = r;
   endfunction

   // ----------------------------------------------------------------------------
   // Stack sequencer state
   // ----------------------------------------------------------------------------
   cfsp_state_e state;
   cfsp_state_e next_state;
   logic [2:0]  count;
   logic [2:0]  next_count;
   logic [2:0]  total;
   logic [2:0]  next_total;
   logic        isIrq;
   logic        next_isIrq;
   logic [39:0] frame;
   logic [39:0] next_frame;
   logic [1:0]  entryPrio;
   logic [1:0]  next_entryPrio;
   logic [7:0]  flags;
   logic [7:0]  next_flags;
   cfsp_mem_s   next_memPort;
   logic [7:0]  next_popData;
   logic        next_popValid;
   logic        popPending;
   logic        next_popPending;
   logic        popToFlags;
   logic        next_popToFlags;
   logic [7:0]  spLow;
   logic        spReload;
   logic        spLoad;
   logic        spDec;
   logic        spInc;

   cfsp_stack_ptr u_sp (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .reload    (spReload),
      .load      (spLoad),
      .loadValue (stackReq.lowByte),
      .decrement (spDec),
      .increment (spInc),
      .lowByte   (spLow)
   );

   // ----------------------------------------------------------------------------
   // Flag update
   // ----------------------------------------------------------------------------
   // Flags written by a popped flags byte win over a same-cycle ALU update; ALU requests
   // are not held off while the sequencer is busy, so the two can overlap.
   always_comb begin
      next_flags = flags;
      case (aluReq.op)
         CFSP_OP_ADD: begin
            next_flags[`CFSP_BIT_HALF]     = aluReq.halfCarry;
            next_flags[`CFSP_BIT_NEGATIVE] = aluReq.result[7];
            next_flags[`CFSP_BIT_ZERO]     = (aluReq.result == 8'h00);
            next_flags[`CFSP_BIT_CARRY]    = aluReq.carry;
         end
         CFSP_OP_ARITH: begin
            next_flags[`CFSP_BIT_NEGATIVE] = aluReq.result[7];
            next_flags[`CFSP_BIT_ZERO]     = (aluReq.result == 8'h00);
            next_flags[`CFSP_BIT_CARRY]    = aluReq.carry;
         end
         CFSP_OP_LOGIC: begin
            next_flags[`CFSP_BIT_NEGATIVE] = aluReq.result[7];
            next_flags[`CFSP_BIT_ZERO]     = (aluReq.result == 8'h00);
         end
         CFSP_OP_SHIFT: begin
            next_flags[`CFSP_BIT_NEGATIVE] = aluReq.result[7];
            next_flags[`CFSP_BIT_ZERO]     = (aluReq.result == 8'h00);
            next_flags[`CFSP_BIT_CARRY]    = aluReq.carry;
         end
         CFSP_OP_BITTEST: next_flags[`CFSP_BIT_CARRY] = aluReq.carry;
         CFSP_OP_SETC:    next_flags[`CFSP_BIT_CARRY] = 1'b1;
         CFSP_OP_CLRC:    next_flags[`CFSP_BIT_CARRY] = 1'b0;
         CFSP_OP_PRIOWR:  next_flags = set_prio(flags, aluReq.value[1:0]);
         CFSP_OP_FLAGSWR: next_flags = aluReq.value | `CFSP_FLAGS_ONES;
         default:         next_flags = flags;
      endcase
      if (state == CFSP_ST_IDLE && stackReq.op == CFSP_SP_IRQ) begin
         next_flags = set_prio(next_flags, stackReq.entryPrio);
      end
      if (popPending && popToFlags) begin
         next_flags = memReadData | `CFSP_FLAGS_ONES;
      end
   end

   // ----------------------------------------------------------------------------
   // Stack sequencer
   // ----------------------------------------------------------------------------
   // One byte moves per cycle. Pops read at the incremented address; the read data is
   // sampled in the same cycle as the strobe and shows on popData one cycle later.
   always_comb begin
      next_state      = state;
      next_count      = count;
      next_total      = total;
      next_isIrq      = isIrq;
      next_frame      = frame;
      next_entryPrio  = entryPrio;
      next_memPort    = '0;
      next_popData    = popData;
      next_popValid   = 1'b0;
      next_popPending = 1'b0;
      next_popToFlags = 1'b0;
      spReload        = 1'b0;
      spLoad          = 1'b0;
      spDec           = 1'b0;
      spInc           = 1'b0;
      if (popPending) begin
         next_popData  = memReadData;
         next_popValid = 1'b1;
      end
      case (state)
         CFSP_ST_IDLE: begin
            case (stackReq.op)
               CFSP_SP_RESET: spReload = 1'b1;
               CFSP_SP_LOAD:  spLoad = 1'b1;
               CFSP_SP_PUSH: begin
                  next_memPort = '{write: 1'b1, read: 1'b0, addr: {`CFSP_STACK_PAGE, spLow},
                                   data: stackReq.accum};
                  spDec = 1'b1;
               end
               CFSP_SP_POP: begin
                  spInc = 1'b1;
                  next_memPort = '{write: 1'b0, read: 1'b1, addr: {`CFSP_STACK_PAGE, spLow + 8'h01},
                                   data: 8'h00};
                  next_popPending = 1'b1;
               end
               CFSP_SP_CALL, CFSP_SP_IRQ: begin
                  next_frame = {flags, stackReq.accum, stackReq.indexReg,
                                stackReq.pcHigh, stackReq.pcLow};
                  next_isIrq = (stackReq.op == CFSP_SP_IRQ);
                  next_total = next_isIrq ? `CFSP_IRQ_BYTES : `CFSP_CALL_BYTES;
                  next_count = 3'h0;
                  next_state = CFSP_ST_PUSHSEQ;
               end
               CFSP_SP_RET, CFSP_SP_IRQ_RETURN_INSTR: begin
                  next_isIrq = (stackReq.op == CFSP_SP_IRQ_RETURN_INSTR);
                  next_total = next_isIrq ? `CFSP_IRQ_BYTES : `CFSP_CALL_BYTES;
                  next_count = 3'h0;
                  next_state = CFSP_ST_POPSEQ;
               end
               default: next_state = CFSP_ST_IDLE;
            endcase
         end
         CFSP_ST_PUSHSEQ: begin
            next_memPort = '{write: 1'b1, read: 1'b0, addr: {`CFSP_STACK_PAGE, spLow},
                             data: frame[7:0]};
            next_frame = {8'h00, frame[39:8]};
            spDec      = 1'b1;
            next_count = count + 3'h1;
            if (next_count == total) begin
               next_state = CFSP_ST_IDLE;
            end
         end
         CFSP_ST_POPSEQ: begin
            spInc = 1'b1;
            next_memPort = '{write: 1'b0, read: 1'b1, addr: {`CFSP_STACK_PAGE, spLow + 8'h01},
                             data: 8'h00};
            next_popPending = 1'b1;
            next_popToFlags = isIrq && (count == 3'h0);
            next_count = count + 3'h1;
            if (next_count == total) begin
               next_state = CFSP_ST_IDLE;
            end
         end
         default: next_state = CFSP_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= CFSP_ST_IDLE;
         count      <= 3'h0;
         total      <= 3'h0;
         isIrq      <= 1'b0;
         frame      <= '0;
         entryPrio  <= 2'h0;
         flags      <= `CFSP_FLAGS_RESET;
         memPort    <= '0;
         popData    <= 8'h00;
         popValid   <= 1'b0;
         popPending <= 1'b0;
         popToFlags <= 1'b0;
      end else begin
         state      <= next_state;
         count      <= next_count;
         total      <= next_total;
         isIrq      <= next_isIrq;
         frame      <= next_frame;
         entryPrio  <= next_entryPrio;
         flags      <= next_flags;
         memPort    <= next_memPort;
         popData    <= next_popData;
         popValid   <= next_popValid;
         popPending <= next_popPending;
         popToFlags <= next_popToFlags;
      end
   end

   // ----------------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         condition_flags   <= `CFSP_FLAGS_RESET;
         stack_top_pointer <= `CFSP_STACK_RESET;
         branchTests       <= 4'h0;
         priorityLevel     <= 2'h3;
         busy              <= 1'b0;
      end else begin
         condition_flags   <= next_flags;
         stack_top_pointer <= {`CFSP_STACK_PAGE, u_sp.next_lowByte};
         branchTests       <= {next_flags[`CFSP_BIT_HALF], next_flags[`CFSP_BIT_NEGATIVE],
                               next_flags[`CFSP_BIT_ZERO], next_flags[`CFSP_BIT_CARRY]};
         priorityLevel     <= prio_level({next_flags[`CFSP_BIT_PRIO_HIGH],
                                          next_flags[`CFSP_BIT_PRIO_LOW]});
         busy              <= (next_state != CFSP_ST_IDLE);
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_half;
      @(posedge ref_clk) disable iff (!reset_n)
      (aluReq.op == CFSP_OP_ADD && !popPending && state == CFSP_ST_IDLE && stackReq.op != CFSP_SP_IRQ)
      |=> condition_flags[`CFSP_BIT_HALF] == $past(aluReq.halfCarry);
   endproperty
   a_half: assert property (p_half) else $error("half carry wrong after add");

   property p_neg_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      (aluReq.op inside {CFSP_OP_ADD, CFSP_OP_ARITH, CFSP_OP_LOGIC} && !popPending)
      |=> condition_flags[`CFSP_BIT_NEGATIVE] == $past(aluReq.result[7])
          && condition_flags[`CFSP_BIT_ZERO] == ($past(aluReq.result) == 8'h00);
   endproperty
   a_neg_zero: assert property (p_neg_zero) else $error("negative or zero flag wrong");

   property p_zero;
      @(posedge ref_clk) disable iff (!reset_n)
      (aluReq.op == CFSP_OP_LOGIC && aluReq.result == 8'h00 && !popPending)
      |=> condition_flags[`CFSP_BIT_ZERO] ##1 1'b1;
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag not set");

   property p_carry;
      @(posedge ref_clk) disable iff (!reset_n)
      (aluReq.op == CFSP_OP_SETC && !popPending) |=> condition_flags[`CFSP_BIT_CARRY];
   endproperty
   a_carry: assert property (p_carry) else $error("set carry ignored");

   property p_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      (aluReq.op == CFSP_OP_NONE && !popPending && !(state == CFSP_ST_IDLE && stackReq.op == CFSP_SP_IRQ))
      |=> $stable(condition_flags);
   endproperty
   a_hold: assert property (p_hold) else $error("flags changed without cause");

   property p_page;
      @(posedge ref_clk) disable iff (!reset_n)
      stack_top_pointer[15:8] == `CFSP_STACK_PAGE;
   endproperty
   a_page: assert property (p_page) else $error("stack page not fixed");

   property p_reload;
      @(posedge ref_clk) disable iff (!reset_n)
      (state == CFSP_ST_IDLE && stackReq.op == CFSP_SP_RESET) |=> stack_top_pointer == `CFSP_STACK_RESET;
   endproperty
   a_reload: assert property (p_reload) else $error("reload did not give top");

   property p_push;
      @(posedge ref_clk) disable iff (!reset_n)
      (state == CFSP_ST_IDLE && stackReq.op == CFSP_SP_PUSH)
      |=> memPort.write && memPort.addr == $past(stack_top_pointer) && stack_top_pointer[7:0] == memPort.addr[7:0] - 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("push order wrong");

   property p_irq_len;
      @(posedge ref_clk) disable iff (!reset_n)
      (state == CFSP_ST_IDLE && stackReq.op == CFSP_SP_IRQ) |=> busy[*5] ##1 !busy;
   endproperty
   a_irq_len: assert property (p_irq_len) else $error("interrupt frame not five bytes");

   property p_entry_prio;
      @(posedge ref_clk) disable iff (!reset_n)
      (state == CFSP_ST_IDLE && stackReq.op == CFSP_SP_IRQ && !popPending)
      |=> {condition_flags[5], condition_flags[3]} == $past(stackReq.entryPrio);
   endproperty
   a_entry_prio: assert property (p_entry_prio) else $error("entry priority not loaded");

   c_irq:  cover property (@(posedge ref_clk) disable iff (!reset_n) state == CFSP_ST_PUSHSEQ && isIrq);
   c_irq_return_instr: cover property (@(posedge ref_clk) disable iff (!reset_n) popToFlags);
   c_wrap: cover property (@(posedge ref_clk) disable iff (!reset_n) stack_top_pointer == 16'h0100 ##1
                           stack_top_pointer == `CFSP_STACK_RESET);

endmodule

// ### test/cpu_flags_and_stack_pointer_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin logic [31:0] ev; ev = 32'(ex); comparisons++; if (32'(gt) !== ev) begin \
   mismatches++; $display("unexpected %s expected %h seen %h", nm, ev, 32'(gt)); end end

module cpu_flags_and_stack_pointer_test;
   import cfsp_pkg::*;

   logic                  ref_clk;
   logic                  reset_n;
   cfsp_alu_s             aluReq;
   cfsp_stack_req_s       stackReq;
   logic [7:0]            memReadData;
   cfsp_mem_s             memPort;
   logic [7:0]            condition_flags;
   logic [15:0]           stack_top_pointer;
   logic [3:0]            branchTests;
   logic [1:0]            priorityLevel;
   logic [7:0]            popData;
   logic                  popValid;
   logic                  busy;
   int                    mismatches;
   int                    comparisons;
   logic [7:0]            expFlags;
   logic [7:0]            expLow;
   logic [7:0]            expMem [256];
   logic [7:0]            ram [256];
   logic [13:0]           flagQ [$];
   logic [23:0]           wrQ [$];
   logic [7:0]            popQ [$];
   logic                  aluSeen;
   logic [31:0]           r;

   cfsp_core_regs dut (
      .ref_clk           (ref_clk),
      .reset_n           (reset_n),
      .aluReq            (aluReq),
      .stackReq          (stackReq),
      .memReadData       (memReadData),
      .memPort           (memPort),
      .condition_flags   (condition_flags),
      .stack_top_pointer (stack_top_pointer),
      .branchTests       (branchTests),
      .priorityLevel     (priorityLevel),
      .popData           (popData),
      .popValid          (popValid),
      .busy              (busy)
   );

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------------------
   // Result watcher and stack RAM
   // ----------------------------------------------------------------------------
   // The RAM read line is inverted when idle so a stale byte is never mistaken for data.
   always @(posedge ref_clk) begin
      aluSeen = reset_n === 1'b1 && aluReq.op != CFSP_OP_NONE;
      #1;
      if (aluSeen) begin
         if (flagQ.size() == 0) flagQ.push_back('x);
         `CHK("flags", flagQ.pop_front(), {condition_flags, branchTests, priorityLevel})
      end
      if (memPort.write === 1'b1) begin
         ram[memPort.addr[7:0]] = memPort.data;
         if (wrQ.size() == 0) wrQ.push_back('x);
         `CHK("stack write", wrQ.pop_front(), {memPort.addr, memPort.data})
      end
      if (popValid === 1'b1) begin
         if (popQ.size() == 0) popQ.push_back('x);
         `CHK("pop data", popQ.pop_front(), popData)
      end
      if (memPort.read === 1'b1) memReadData = ram[memPort.addr[7:0]];
      else memReadData = ~memReadData;
   end

   task automatic end_sim;
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [1:0] lvl(input logic [1:0] p);
      return {~(p[1] ^ p[0]), p[0]};
   endfunction

   task automatic alu(input cfsp_op_e op, input logic [7:0] res, input logic c, input logic h, input logic [7:0] v);
      aluReq = '{op, res, c, h, v};
      if (op inside {CFSP_OP_ADD, CFSP_OP_ARITH, CFSP_OP_SHIFT, CFSP_OP_BITTEST}) expFlags[0] = c;
      if (op == CFSP_OP_ADD) expFlags[4] = h;
      if (op inside {CFSP_OP_ADD, CFSP_OP_LOGIC, CFSP_OP_ARITH, CFSP_OP_SHIFT}) begin
         {expFlags[2], expFlags[1]} = {res[7], res == 8'h00};
      end
      if (op == CFSP_OP_FLAGSWR) expFlags = v | 8'hC0;
      if (op == CFSP_OP_SETC) expFlags[0] = 1'b1;
      if (op == CFSP_OP_CLRC) expFlags[0] = 1'b0;
      if (op == CFSP_OP_PRIOWR) {expFlags[5], expFlags[3]} = v[1:0];
      flagQ.push_back({expFlags, expFlags[4], expFlags[2:0], lvl({expFlags[5], expFlags[3]})});
      @(posedge ref_clk);
      #1;
   endtask

   task automatic nw(input logic [7:0] d);
      wrQ.push_back({8'h01, expLow, d});
      expMem[expLow] = d;
      expLow--;
   endtask

   task automatic np;
      expLow++;
      popQ.push_back(expMem[expLow]);
   endtask

   task automatic stk(input cfsp_spop_e op, input logic [7:0] low, input logic [7:0] a, input logic [1:0] pr,
                      input logic refuse);
      @(posedge ref_clk);
      #1;
      stackReq = '{op, low, a ^ 8'h3C, a ^ 8'hC3, a + 8'h01, a, pr};
      case (op)
         CFSP_SP_PUSH:  nw(a);
         CFSP_SP_POP:   np();
         CFSP_SP_LOAD:  expLow = low;
         CFSP_SP_RESET: expLow = 8'hFF;
         CFSP_SP_CALL: begin
            nw(a ^ 8'h3C);
            nw(a ^ 8'hC3);
         end
         CFSP_SP_RET:   repeat (2) np();
         CFSP_SP_IRQ: begin
            nw(a ^ 8'h3C);
            nw(a ^ 8'hC3);
            nw(a + 8'h01);
            nw(a);
            nw(expFlags);
            {expFlags[5], expFlags[3]} = pr;
         end
         CFSP_SP_IRQ_RETURN_INSTR: begin
            expFlags = expMem[expLow + 8'h01];
            repeat (5) np();
         end
         default: ;
      endcase
      @(posedge ref_clk);
      #1;
      // A request held while busy must be dropped by the block without any stack access.
      stackReq.op = refuse ? CFSP_SP_PUSH : CFSP_SP_NONE;
      for (int i = 0; i < 20 && busy !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
         stackReq.op = CFSP_SP_NONE;
      end
      if (busy !== 1'b0) begin
         mismatches++;
         end_sim();
      end
      `CHK("stack pointer", {8'h01, expLow}, stack_top_pointer)
   endtask

   task automatic chk_rst;
      `CHK("reset pointer", 16'h01FF, stack_top_pointer)
      `CHK("reset level", 2'h3, priorityLevel)
      `CHK("busy", 1'b0, busy)
   endtask

   initial begin
      #(25 * 20000);
      mismatches++;
      end_sim();
   end

   initial begin
      reset_n = 1'b0;
      aluReq = '0;
      stackReq = '0;
      memReadData = 8'h00;
      expFlags = 8'hE8;
      expLow = 8'hFF;
      mismatches = 0;
      comparisons = 0;
      r = $urandom(32'h8630);
      repeat (6) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      chk_rst();
      for (int i = 0; i < 4; i++) alu(CFSP_OP_PRIOWR, 8'h00, 1'b0, 1'b0, 8'(i));
      alu(CFSP_OP_ADD, 8'h00, 1'b1, 1'b1, 8'h00);
      for (int i = 0; i < 24; i++) begin
         r = $urandom();
         alu(cfsp_op_e'({2'h0, r[11:10]} + 4'h1), r[7:0], r[8], r[9], 8'h00);
      end
      alu(CFSP_OP_BITTEST, 8'h00, ~r[12], 1'b1, 8'h00);
      alu(CFSP_OP_FLAGSWR, 8'h00, 1'b0, 1'b0, r[7:0] ^ 8'h28);
      alu(CFSP_OP_SETC, 8'h00, 1'b0, 1'b0, 8'h00);
      alu(CFSP_OP_LOGIC, 8'h80, 1'b0, 1'b0, 8'h00);
      alu(CFSP_OP_CLRC, 8'h00, 1'b1, 1'b1, 8'h00);
      aluReq.op = CFSP_OP_NONE;
      stk(CFSP_SP_PUSH, 8'h00, 8'hA5, 2'h0, 1'b0);
      stk(CFSP_SP_PUSH, 8'h00, 8'h5A, 2'h0, 1'b0);
      stk(CFSP_SP_POP, 8'h00, 8'h00, 2'h0, 1'b0);
      stk(CFSP_SP_LOAD, 8'h00, 8'h00, 2'h0, 1'b0);
      stk(CFSP_SP_PUSH, 8'h00, 8'h77, 2'h0, 1'b0);
      stk(CFSP_SP_POP, 8'h00, 8'h00, 2'h0, 1'b0);
      stk(CFSP_SP_RESET, 8'h00, 8'h00, 2'h0, 1'b0);
      stk(CFSP_SP_CALL, 8'h00, 8'h12, 2'h0, 1'b0);
      stk(CFSP_SP_RET, 8'h00, 8'h00, 2'h0, 1'b0);
      stk(CFSP_SP_IRQ, 8'h00, 8'h34, 2'h1, 1'b1);
      `CHK("entry level", 2'h1, priorityLevel)
      stk(CFSP_SP_IRQ_RETURN_INSTR, 8'h00, 8'h00, 2'h0, 1'b0);
      `CHK("restored flags", expFlags, condition_flags)
      // The last popped byte of the frame is still on its way out.
      repeat (2) @(posedge ref_clk);
      #1;
      reset_n = 1'b0;
      expLow = 8'hFF;
      @(posedge ref_clk);
      #1;
      chk_rst();
      `CHK("reset flags", 8'hE8, condition_flags)
      reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("pending", 0, flagQ.size() + wrQ.size() + popQ.size())
      end_sim();
   end
endmodule
